/* File: src/uil_top.sv */
// usb interrupt logic with core interrupt sequencer and register slave
// assumes avalon-mm master on the core clock, usb engine pulses
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uil_defs.svh"
module uil_top
  import uil_pkg::*;
#(
  parameter int FRAME_CYC = 12000
) (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [15:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        SOF_VALID_I,
  input  wire logic [10:0] FRAME_NUM_I,
  input  wire logic [4:0]  EP_OUT_RX_I,
  input  wire logic [4:0]  EP_TX_DONE_I,
  input  wire logic [4:0]  EP_TX_READY_CLR_I,
  input  wire logic [4:0]  EP_SETUP_RX_I,
  input  wire logic        REMOTE_WAKE_I,
  input  wire logic        GLOBAL_SUSPEND_I,
  input  wire logic        RESUME_I,
  input  wire logic        BUS_RESET_I,
  input  wire logic        LINE1_I,
  input  wire logic        INSN_BOUNDARY_I,
  input  wire logic        SLEEP_INSN_I,
  input  wire logic        RETI_INSN_I,
  input  wire logic        WAKE_I,
  output logic             IRQ_ENTRY_O,
  output logic             PUSH_PC_O,
  output logic             POP_PC_O,
  output logic             VECTOR_EXEC_O,
  output logic [1:0]       VECTOR_SEL_O,
  output logic             SLEEP_O,
  output logic             POWER_DOWN_O,
  output logic             HUB_SUSPEND_O,
  output logic             RESUME_PROP_O,
  output logic [10:0]      FRAME_NUM_O,
  output logic             USB_IRQ_O
);
  if (FRAME_CYC <= 16 || FRAME_CYC > 65535) begin : g_bad_frame
    $error("FRAME_CYC out of range");
  end

  // flag visible ten clocks ahead of next frame start
  localparam logic [15:0] EOF2_AT =
    16'(FRAME_CYC) - `UIL_EOF2_LEAD - 16'h0001;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    uil_state_e  st;
    logic [2:0]  cnt;
    logic [1:0]  vec;
    uil_byte_t   isr;
    uil_byte_t   ier;
    uil_byte_t   imsk;
    uil_byte_t   spr;
    uil_byte_t   sprie;
    uil_byte_t   mcu_control;
    uil_byte_t   general_mask_register;
    logic        gie;
    logic        line1_prev;
    logic        line1_flag;
    logic [10:0] frame;
    logic [15:0] ftimer;
    logic        ack;
    logic [31:0] rdata;
    logic        hub_susp;
    logic        rsm_prop;
  } uil_state_s;

  uil_state_s q, d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    return a == o;
  endfunction

  logic       req_go;
  logic [7:0] ep_evt;
  logic       line1_evt;
  logic       usb_req;
  logic       spr_req;
  logic [1:0] sense;

  // endpoint events, index 3 is hub ep0, slots map to status bits
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ep
      localparam int B = (g == 4) ? `UIL_B_FE3 : g;
      assign ep_evt[B] = EP_OUT_RX_I[g] | EP_SETUP_RX_I[g]
        | (EP_TX_READY_CLR_I[g] & EP_TX_DONE_I[g])
        | EP_TX_DONE_I[g];
    end
  endgenerate
  assign ep_evt[7:5] = 3'h0;

  always_comb begin
    sense = q.mcu_control[`UIL_B_SENSE_HI:`UIL_B_SENSE_LO];
    case (sense)
      2'b00:   line1_evt = ~LINE1_I;
      2'b10:   line1_evt = q.line1_prev & ~LINE1_I;
      2'b11:   line1_evt = ~q.line1_prev & LINE1_I;
      default: line1_evt = 1'b0;
    endcase
  end

  assign usb_req = |(q.isr & q.ier & ~q.imsk & `UIL_ISR_MASK);
  assign spr_req = |(q.spr & q.sprie & `UIL_SPR_MASK);
  assign req_go  = q.gie & (usb_req | spr_req
    | (q.line1_flag & q.general_mask_register[`UIL_B_LINE1_EN]));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] wb;
    logic       wr;
    wb = AVS_WRITEDATA_I[7:0];
    wr = AVS_WRITE_I & q.ack; // write lands as the wait ends
    d = q;
    d.ack = (AVS_READ_I | AVS_WRITE_I) & ~q.ack;
    d.line1_prev = LINE1_I;

    // frame timer and usb status
    d.ftimer = SOF_VALID_I ? 16'h0000 : q.ftimer + 16'h0001;
    if (SOF_VALID_I) begin
      d.frame = FRAME_NUM_I;
    end
    if (wr && hit(AVS_ADDRESS_I, `UIL_OFF_IACK)) begin
      d.isr = q.isr & ~wb;
    end
    d.isr = d.isr | ep_evt;
    d.isr[`UIL_B_SOF] = d.isr[`UIL_B_SOF] | SOF_VALID_I;
    d.isr[`UIL_B_EOF2] = d.isr[`UIL_B_EOF2]
      | (q.ftimer == EOF2_AT);
    d.isr[`UIL_B_RSVD] = 1'b0;

    // suspend and resume: write zero clears
    if (wr && hit(AVS_ADDRESS_I, `UIL_OFF_SPR)) begin
      d.spr = q.spr & (wb | ~`UIL_SPR_MASK);
    end
    d.spr[`UIL_B_RWUP] = d.spr[`UIL_B_RWUP] | REMOTE_WAKE_I;
    d.spr[`UIL_B_SUSP] = d.spr[`UIL_B_SUSP] | GLOBAL_SUSPEND_I;
    d.spr[`UIL_B_RSM] = d.spr[`UIL_B_RSM] | RESUME_I;
    d.spr[`UIL_B_BUSRST] = d.spr[`UIL_B_BUSRST]
      | (BUS_RESET_I & q.sprie[`UIL_B_BUSRST]);
    d.spr = d.spr & `UIL_SPR_MASK;
    if (GLOBAL_SUSPEND_I) begin
      d.hub_susp = 1'b1;
    end
    if (RESUME_I) begin
      d.hub_susp = 1'b0;
    end
    d.rsm_prop = RESUME_I;

    // control registers
    if (wr) begin
      if (hit(AVS_ADDRESS_I, `UIL_OFF_IER))
        d.ier = wb & `UIL_ISR_MASK;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_IMSK))
        d.imsk = wb & `UIL_ISR_MASK;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_SPRIE)) d.sprie = wb;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_MCU_CONTROL)) d.mcu_control = wb & `UIL_MCU_MASK;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_GENERAL_MASK_REGISTER)) d.general_mask_register = wb & 8'h80;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_CORE))  d.gie = wb[`UIL_B_GIE];
    end

    // line one flag, cleared by write of one or on line one vector entry
    if (wr && hit(AVS_ADDRESS_I, `UIL_OFF_GENERAL_MASK_REGISTER) && wb[0]) begin
      d.line1_flag = 1'b0;
    end
    if (line1_evt) begin
      d.line1_flag = 1'b1;
    end

    // core interrupt sequencer
    d.cnt = q.cnt - 3'h1;
    case (q.st)
      UIL_RUN: begin
        if (req_go && INSN_BOUNDARY_I) begin
          d.st  = UIL_ENTRY;
          d.cnt = `UIL_ENTRY_CYC - 3'h1;
          d.gie = 1'b0;
          d.vec = usb_req ? 2'd1 : (spr_req ? 2'd2 : 2'd3);
          if (!(usb_req | spr_req)) d.line1_flag = line1_evt;
        end else if (RETI_INSN_I && INSN_BOUNDARY_I) begin
          d.st  = UIL_RETI;
          d.cnt = `UIL_RETI_CYC - 3'h1;
        end else if (SLEEP_INSN_I && INSN_BOUNDARY_I
                     && q.mcu_control[`UIL_B_SLEEP_ARM]) begin
          d.st = UIL_SLEEP;
        end
      end
      UIL_ENTRY: begin
        if (q.cnt == 3'h0) begin
          d.st  = UIL_JUMP;
          d.cnt = `UIL_JMP_CYC - 3'h1;
        end
      end
      UIL_JUMP: begin
        if (q.cnt == 3'h0) d.st = UIL_RUN;
      end
      UIL_RETI: begin
        if (q.cnt == 3'h0) begin
          d.st  = UIL_ONE_INSN;
          d.gie = 1'b1;
        end
      end
      UIL_ONE_INSN: begin
        if (INSN_BOUNDARY_I) d.st = UIL_RUN;
      end
      UIL_SLEEP: begin
        if (WAKE_I || req_go) d.st = UIL_RUN;
      end
      default: d.st = UIL_RUN;
    endcase

    // read data
    if (AVS_READ_I && !q.ack) begin
      d.rdata = 32'h0000_0000;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_ISR))   d.rdata[7:0] = q.isr;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_IMSK))  d.rdata[7:0] = q.imsk;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_IER))   d.rdata[7:0] = q.ier;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_SPR))   d.rdata[7:0] = q.spr;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_SPRIE)) d.rdata[7:0] = q.sprie;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_MCU_CONTROL)) d.rdata[7:0] = q.mcu_control;
      if (hit(AVS_ADDRESS_I, `UIL_OFF_GENERAL_MASK_REGISTER))
        d.rdata[7:0] = {q.general_mask_register[7], 6'h00, q.line1_flag};
      if (hit(AVS_ADDRESS_I, `UIL_OFF_CORE))  d.rdata[7:0] = {q.gie, 7'h00};
    end

    if (SRST_I) begin
      d = '0;
      d.st = UIL_RUN;
      d.line1_prev = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~q.ack;
  assign AVS_READDATA_O    = q.rdata;
  assign IRQ_ENTRY_O       = q.st == UIL_ENTRY;
  assign PUSH_PC_O         = q.st == UIL_ENTRY && q.cnt >= 3'h2;
  assign POP_PC_O          = q.st == UIL_RETI && q.cnt >= 3'h2;
  assign VECTOR_EXEC_O     = q.st == UIL_JUMP;
  assign VECTOR_SEL_O      = q.vec;
  assign SLEEP_O           = q.st == UIL_SLEEP;
  assign POWER_DOWN_O      = SLEEP_O & q.mcu_control[`UIL_B_SLEEP_SEL];
  assign HUB_SUSPEND_O     = q.hub_susp;
  assign RESUME_PROP_O     = q.rsm_prop;
  assign FRAME_NUM_O       = q.frame;
  assign USB_IRQ_O         = usb_req;
endmodule
`default_nettype wire

/* File: src/uil_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the design file and the bench
`ifndef UIL_DEFS_SVH
`define UIL_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define UIL_OFF_ISR     16'h1FF7
`define UIL_OFF_IMSK    16'h1FF6
`define UIL_OFF_IACK    16'h1FF5
`define UIL_OFF_IER     16'h1FF3
`define UIL_OFF_SPR     16'h1FFA
`define UIL_OFF_SPRIE   16'h1FF9
`define UIL_OFF_MCU_CONTROL   16'h1FFC
`define UIL_OFF_GENERAL_MASK_REGISTER   16'h1FFD
`define UIL_OFF_CORE    16'h1FFE
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UIL_B_SOF       7
`define UIL_B_EOF2      6
`define UIL_B_RSVD      5
`define UIL_B_FE3       4
`define UIL_B_HEP0      3
`define UIL_B_FE2       2
`define UIL_B_FE1       1
`define UIL_B_FE0       0
`define UIL_B_SLEEP_ARM 5
`define UIL_B_SLEEP_SEL 4
`define UIL_B_SENSE_HI  3
`define UIL_B_SENSE_LO  2
`define UIL_B_LINE1_EN  7
`define UIL_B_GIE       7
`define UIL_B_BUSRST    3
`define UIL_B_RWUP      2
`define UIL_B_RSM       1
`define UIL_B_SUSP      0
// ---------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------
`define UIL_RST_REG     8'h00
`define UIL_ISR_MASK    8'hDF
`define UIL_SPR_MASK    8'h0F
`define UIL_MCU_MASK    8'h3C
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define UIL_ENTRY_CYC   3'h4
`define UIL_JMP_CYC     3'h3
`define UIL_RETI_CYC    3'h4
`define UIL_EOF2_LEAD   16'h000A
`endif

/* File: src/uil_pkg.sv */
// types of the usb interrupt logic
// assumes the defs header for all numbers
package uil_pkg;
  typedef enum logic [2:0] {
    UIL_RUN,
    UIL_ENTRY,
    UIL_JUMP,
    UIL_RETI,
    UIL_ONE_INSN,
    UIL_SLEEP
  } uil_state_e;
  typedef logic [7:0] uil_byte_t;
endpackage

/* File: verification/uil_usb_model.sv */
// usb engine model: one-cycle event pulses per command
// assumes the bench raises go_i for one cycle per event
`timescale 1ns/1ps
`default_nettype none
module uil_usb_model
  import uil_pkg::*;
(
  input  wire logic        go_i,
  input  wire logic [3:0]  kind_i,
  input  wire logic [2:0]  ep_i,
  input  wire logic [10:0] fn_i,
  output logic             sof_o,
  output logic [10:0]      fnum_o,
  output logic [4:0]       out_rx_o,
  output logic [4:0]       tx_done_o,
  output logic [4:0]       rdy_clr_o,
  output logic [4:0]       setup_o,
  output logic             wake_o,
  output logic             susp_o,
  output logic             rsm_o,
  output logic             brst_o
);
  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  logic [4:0] sel;
  assign sel       = go_i ? (5'h01 << ep_i) : 5'h00;
  assign sof_o     = go_i && (kind_i == 4'h0);
  assign fnum_o    = sof_o ? fn_i : ~fn_i;
  assign out_rx_o  = (kind_i == 4'h1) ? sel : 5'h00;
  assign tx_done_o = (kind_i == 4'h2 || kind_i == 4'h3) ? sel : 5'h00;
  assign rdy_clr_o = (kind_i == 4'h3) ? sel : 5'h00;
  assign setup_o   = (kind_i == 4'h4) ? sel : 5'h00;
  assign wake_o    = go_i && (kind_i == 4'h5);
  assign susp_o    = go_i && (kind_i == 4'h6);
  assign rsm_o     = go_i && (kind_i == 4'h7);
  assign brst_o    = go_i && (kind_i == 4'h8);
endmodule
`default_nettype wire

/* File: verification/uil_top_properties.sv */
// checker of bus and sequencer timing at the top ports
// assumes binding to uil_top
`timescale 1ns/1ps
`default_nettype none
module uil_top_props (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        SOF_VALID_I,
  input wire logic [10:0] FRAME_NUM_I,
  input wire logic [10:0] FRAME_NUM_O,
  input wire logic        IRQ_ENTRY_O,
  input wire logic        PUSH_PC_O,
  input wire logic        POP_PC_O,
  input wire logic        VECTOR_EXEC_O,
  input wire logic        SLEEP_O,
  input wire logic        POWER_DOWN_O,
  input wire logic        SLEEP_INSN_I,
  input wire logic        INSN_BOUNDARY_I
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_wait_one: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("wait length");
  a_rd_upper: assert property (AVS_READDATA_O[31:8] == 24'h0)
    else $error("upper read bits");
  a_entry_len: assert property ($rose(IRQ_ENTRY_O) |->
    IRQ_ENTRY_O [*4] ##1 !IRQ_ENTRY_O) else $error("entry length");
  a_push_two: assert property ($rose(IRQ_ENTRY_O) |->
    PUSH_PC_O [*2] ##1 !PUSH_PC_O) else $error("push length");
  a_vector_jump: assert property ($fell(IRQ_ENTRY_O) |->
    VECTOR_EXEC_O [*3] ##1 !VECTOR_EXEC_O) else $error("jump length");
  a_entry_bound: assert property ($rose(IRQ_ENTRY_O) |->
    $past(INSN_BOUNDARY_I)) else $error("entry off boundary");
  a_pop_two: assert property ($rose(POP_PC_O) |->
    POP_PC_O [*2] ##1 !POP_PC_O) else $error("pop length");
  a_one_insn: assert property ($fell(POP_PC_O) |->
    !IRQ_ENTRY_O [*4]) else $error("entry too soon");
  a_sleep_cause: assert property ($rose(SLEEP_O) |->
    $past(SLEEP_INSN_I && INSN_BOUNDARY_I)) else $error("sleep cause");
  a_pdown_sleep: assert property (POWER_DOWN_O |-> SLEEP_O)
    else $error("power-down awake");
  a_frame_keep: assert property (SOF_VALID_I |=>
    FRAME_NUM_O == $past(FRAME_NUM_I)) else $error("frame number");
endmodule
bind uil_top uil_top_props u_uil_top_props (.*);
`default_nettype wire

/* File: verification/test_usb_mcu_interrupt_logic.sv */
// bench: register, usb event, interrupt entry, line and sleep tests
// assumes uil_top, uil_usb_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "uil_defs.svh"
module test_usb_mcu_interrupt_logic;
  import uil_pkg::*;
  // ---------------------------------------------------------------
  // signals, instances, tasks
  // ---------------------------------------------------------------
  logic        CLK_I, SRST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
  logic        SOF_VALID_I, REMOTE_WAKE_I, GLOBAL_SUSPEND_I, RESUME_I;
  logic        BUS_RESET_I, LINE1_I, INSN_BOUNDARY_I, SLEEP_INSN_I;
  logic        RETI_INSN_I, WAKE_I, IRQ_ENTRY_O, PUSH_PC_O, POP_PC_O;
  logic        VECTOR_EXEC_O, SLEEP_O, POWER_DOWN_O, HUB_SUSPEND_O;
  logic        RESUME_PROP_O, USB_IRQ_O, go;
  logic [15:0] AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
  logic [10:0] FRAME_NUM_I, FRAME_NUM_O, fn;
  logic [4:0]  EP_OUT_RX_I, EP_TX_DONE_I, EP_TX_READY_CLR_I;
  logic [4:0]  EP_SETUP_RX_I;
  logic [3:0]  kind;
  logic [2:0]  ep;
  logic [1:0]  VECTOR_SEL_O;
  uil_byte_t   rdv;
  int          fails, checked, cyc;
  logic [3:0]  ekind [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h1};
  logic [1:0]  lmode [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic        lpre  [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  uil_byte_t   lexp  [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
  uil_top #(.FRAME_CYC(100)) u_uil_top (.*);
  uil_usb_model u_uil_usb_model (.go_i(go), .kind_i(kind), .ep_i(ep),
    .fn_i(fn), .sof_o(SOF_VALID_I), .fnum_o(FRAME_NUM_I),
    .out_rx_o(EP_OUT_RX_I), .tx_done_o(EP_TX_DONE_I),
    .rdy_clr_o(EP_TX_READY_CLR_I), .setup_o(EP_SETUP_RX_I),
    .wake_o(REMOTE_WAKE_I), .susp_o(GLOBAL_SUSPEND_I),
    .rsm_o(RESUME_I), .brst_o(BUS_RESET_I));
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [10:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input uil_byte_t d);
    @(posedge CLK_I);
    AVS_ADDRESS_I   <= a;
    AVS_WRITEDATA_I <= {24'h0, d};
    AVS_WRITE_I     <= w;
    AVS_READ_I      <= !w;
    do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    rdv = AVS_READDATA_O[7:0];
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I  <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input uil_byte_t d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(string n, logic [15:0] a, uil_byte_t m, uil_byte_t e);
    acc(1'b0, a, 8'h00);
    chk(n, rdv & m, e);
  endtask
  task automatic pl(input logic [3:0] k);
    @(posedge CLK_I);
    go   <= 1'b1;
    kind <= k;
    @(posedge CLK_I);
    go   <= 1'b0;
  endtask
  task automatic ins(input logic s, r);
    @(posedge CLK_I);
    SLEEP_INSN_I <= s;
    RETI_INSN_I  <= r;
    @(posedge CLK_I);
    SLEEP_INSN_I <= 1'b0;
    RETI_INSN_I  <= 1'b0;
    repeat (3) @(posedge CLK_I);
  endtask
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    {AVS_READ_I, AVS_WRITE_I, go, SLEEP_INSN_I, RETI_INSN_I, WAKE_I} = '0;
    {AVS_ADDRESS_I, AVS_WRITEDATA_I, kind, ep, fails, checked, cyc} = '0;
    {SRST_I, INSN_BOUNDARY_I, LINE1_I} = 3'h7;
    fn = 11'h5A3;
    repeat (3) @(posedge CLK_I);
    SRST_I <= 1'b0;
    rdc("ier", `UIL_OFF_IER, 8'hFF, 8'h00);
    rdc("imsk", `UIL_OFF_IMSK, 8'hFF, 8'h00);
    rdc("mcu", `UIL_OFF_MCU_CONTROL, 8'hFF, 8'h00);
    wr(16'h0000, 8'hFF);
    rdc("unmapped", 16'h0000, 8'hFF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ep <= 3'(i);
      pl(ekind[i]);
    end
    rdc("isr_ep", `UIL_OFF_ISR, 8'hBF, 8'h1F);
    wr(`UIL_OFF_ISR, 8'hFF);
    rdc("isr_ro", `UIL_OFF_ISR, 8'hBF, 8'h1F);
    wr(`UIL_OFF_IACK, 8'h1F);
    rdc("isr_ack", `UIL_OFF_ISR, 8'hBF, 8'h00);
    ep <= 3'h0;
    pl(4'h0);
    @(negedge CLK_I);
    chk("frame", FRAME_NUM_O, fn);
    rdc("isr_sof", `UIL_OFF_ISR, 8'hBF, 8'h80);
    chk("irq_off", USB_IRQ_O, 1'b0);
    wr(`UIL_OFF_IER, 8'h80);
    @(negedge CLK_I);
    chk("irq_on", USB_IRQ_O, 1'b1);
    wr(`UIL_OFF_IMSK, 8'h80);
    @(negedge CLK_I);
    chk("irq_mask", USB_IRQ_O, 1'b0);
    wr(`UIL_OFF_IMSK, 8'h00);
    wr(`UIL_OFF_IACK, 8'hC0);
    wr(`UIL_OFF_IER, 8'h40);
    pl(4'h0);
    repeat (89) @(posedge CLK_I);
    @(negedge CLK_I);
    chk("eof2_early", USB_IRQ_O, 1'b0);
    @(negedge CLK_I);
    chk("eof2_due", USB_IRQ_O, 1'b1);
    rdc("isr_eof2", `UIL_OFF_ISR, 8'hE0, 8'hC0);
    wr(`UIL_OFF_IER, 8'h80);
    wr(`UIL_OFF_IACK, 8'hC0);
    pl(4'h7);
    @(negedge CLK_I);
    chk("rsm_prop", RESUME_PROP_O, 1'b1);
    pl(4'h6);
    pl(4'h5);
    rdc("spr", `UIL_OFF_SPR, 8'h0F, 8'h07);
    chk("hub_susp", HUB_SUSPEND_O, 1'b1);
    wr(`UIL_OFF_SPR, 8'h00);
    rdc("spr_clr", `UIL_OFF_SPR, 8'h0F, 8'h00);
    pl(4'h8);
    rdc("brst_off", `UIL_OFF_SPR, 8'h08, 8'h00);
    wr(`UIL_OFF_SPRIE, 8'h08);
    pl(4'h8);
    rdc("brst_on", `UIL_OFF_SPR, 8'h08, 8'h08);
    wr(`UIL_OFF_SPR, 8'h00);
    wr(`UIL_OFF_SPRIE, 8'h00);
    wr(`UIL_OFF_CORE, 8'h80);
    INSN_BOUNDARY_I <= 1'b0;
    pl(4'h0);
    repeat (3) @(posedge CLK_I);
    chk("mid_insn", IRQ_ENTRY_O, 1'b0);
    INSN_BOUNDARY_I <= 1'b1;
    wait (IRQ_ENTRY_O === 1'b1);
    @(negedge CLK_I);
    chk("vsel", VECTOR_SEL_O, 2'h1);
    wait (VECTOR_EXEC_O === 1'b1);
    wait (VECTOR_EXEC_O === 1'b0);
    ins(1'b0, 1'b1);
    rdc("gie_back", `UIL_OFF_CORE, 8'h80, 8'h80);
    wr(`UIL_OFF_IACK, 8'h80);
    wr(`UIL_OFF_CORE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      LINE1_I <= lpre[i];
      wr(`UIL_OFF_MCU_CONTROL, {4'h0, lmode[i], 2'h0});
      wr(`UIL_OFF_GENERAL_MASK_REGISTER, 8'h81);
      @(posedge CLK_I);
      LINE1_I <= !lpre[i];
      repeat (3) @(posedge CLK_I);
      rdc("line1", `UIL_OFF_GENERAL_MASK_REGISTER, 8'h01, lexp[i]);
    end
    wr(`UIL_OFF_MCU_CONTROL, 8'h10);
    ins(1'b1, 1'b0);
    chk("no_sleep", SLEEP_O, 1'b0);
    wr(`UIL_OFF_MCU_CONTROL, 8'h30);
    ins(1'b1, 1'b0);
    chk("sleep", SLEEP_O, 1'b1);
    chk("pdown", POWER_DOWN_O, 1'b1);
    wr(`UIL_OFF_CORE, 8'h80);
    wait (IRQ_ENTRY_O === 1'b1);
    @(negedge CLK_I);
    chk("vsel_line", VECTOR_SEL_O, 2'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
